// ===== verilog/asso_pkg.sv
// Shared constants and types for the ALU subset datapath
package asso_pkg;
    // Data and address widths
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int BUS_AW = 5;
    localparam int BUS_DW = 32;
    localparam int NIB_W = 4;

    // Register byte offsets on the bus
    localparam logic [4:0] OFS_COMMAND = 5'h00;
    localparam logic [4:0] OFS_WORK = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_FILE_INDEX = 5'h0c;
    localparam logic [4:0] OFS_FILE_DATA = 5'h10;
    localparam logic [4:0] OFS_WATCHDOG = 5'h14;

    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_W = 3;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_ADDR_LSB = 4;
    localparam int CMD_LIT_LSB = 16;
    localparam int CMD_W = 24;

    // Status register bit positions
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_POWER_DOWN = 3;
    localparam int ST_TIME_OUT = 4;
    localparam int ST_ASLEEP = 5;
    localparam int ST_WAKE = 7;

    // Reset values and the prescaler wrap value
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] WDOG_RST = 8'h00;
    localparam logic [7:0] PRESC_RST = 8'h00;
    localparam logic [7:0] PRESC_LAST = 8'hff;
    localparam logic [23:0] CMD_RST = 24'h000000;
    localparam logic [6:0] FIDX_RST = 7'h00;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // Destination select values
    localparam logic DEST_WORK = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Operations the datapath executes
    typedef enum logic [2:0] {
        ASSO_ROTATE_RIGHT_CARRY_OP = 3'h0,
        ASSO_LITERAL_MINUS_WORK_OP = 3'h1,
        ASSO_FILE_MINUS_WORK_OP = 3'h2,
        ASSO_XOR_LITERAL_OP = 3'h3,
        ASSO_XOR_FILE_OP = 3'h4,
        ASSO_NIBBLE_EXCHANGE_OP = 3'h5,
        ASSO_SLEEP_OP = 3'h6,
        ASSO_NO_OP = 3'h7
    } asso_op_e;

    // Core run state
    typedef enum logic [0:0] {
        ASSO_RUN = 1'b0,
        ASSO_ASLEEP = 1'b1
    } asso_state_e;
endpackage

// ===== verilog/asso_alu.sv
// Combinational result and flag logic for one instruction
`timescale 1ns/1ps
module asso_alu (
    // Instruction
    input wire asso_pkg::asso_op_e op,
    input wire logic dest,
    input wire logic [7:0] literal,
    // Operands
    input wire logic [7:0] work,
    input wire logic [7:0] fileValue,
    input wire logic carryIn,
    // Results
    output logic [7:0] result,
    output logic carryOut,
    output logic digitOut,
    output logic zeroOut,
    // Which state the result touches
    output logic writeWork,
    output logic writeFile,
    output logic touchCarry,
    output logic touchDigit,
    output logic touchZero
);
    import asso_pkg::*;

    logic [7:0] minuend; // Literal or file operand of a subtract
    logic [8:0] diff; // Minuend plus inverted work plus one
    logic [4:0] lowDiff; // Same sum on the low nibbles only
    logic fileDest; // Destination bit honoured by this op

    // Two's complement subtract; carry out means no borrow
    always_comb begin
        minuend = (op == ASSO_LITERAL_MINUS_WORK_OP) ? literal : fileValue;
        diff = {1'b0, minuend} + {1'b0, ~work} + 9'h001;
        lowDiff = {1'b0, minuend[NIB_W-1:0]} + {1'b0, ~work[NIB_W-1:0]}
            + 5'h01;
    end

    // Result selection and flag enables per operation
    always_comb begin
        result = work;
        carryOut = carryIn;
        touchCarry = 1'b0;
        touchDigit = 1'b0;
        touchZero = 1'b0;
        fileDest = 1'b0;
        writeWork = 1'b0;
        case (op)
            ASSO_ROTATE_RIGHT_CARRY_OP: begin
                result = {carryIn, fileValue[7:1]}; // RQ13
                carryOut = fileValue[0]; // RQ13
                touchCarry = 1'b1; // RQ4
                fileDest = 1'b1;
            end
            ASSO_LITERAL_MINUS_WORK_OP: begin
                result = diff[7:0]; // RQ6
                carryOut = diff[8]; // RQ7
                touchCarry = 1'b1;
                touchDigit = 1'b1;
                touchZero = 1'b1;
                writeWork = 1'b1; // RQ6
            end
            ASSO_FILE_MINUS_WORK_OP: begin
                result = diff[7:0]; // RQ8
                carryOut = diff[8]; // RQ8
                touchCarry = 1'b1;
                touchDigit = 1'b1;
                touchZero = 1'b1;
                fileDest = 1'b1;
            end
            ASSO_XOR_LITERAL_OP: begin
                result = work ^ literal; // RQ9
                touchZero = 1'b1; // RQ9
                writeWork = 1'b1;
            end
            ASSO_XOR_FILE_OP: begin
                result = work ^ fileValue; // RQ11
                touchZero = 1'b1; // RQ11
                fileDest = 1'b1;
            end
            ASSO_NIBBLE_EXCHANGE_OP: begin
                result = {fileValue[3:0], fileValue[7:4]}; // RQ10
                fileDest = 1'b1;
            end
            default: begin
                result = work;
            end
        endcase
        // File ops with destination bit 0 go to work
        writeWork = writeWork | (fileDest & (dest == DEST_WORK)); // RQ5
    end

    // Destination steering and remaining flags
    assign writeFile = fileDest & (dest == DEST_FILE); // RQ5
    assign digitOut = lowDiff[NIB_W]; // RQ7 RQ8
    assign zeroOut = (result == 8'h00); // RQ12
endmodule

// ===== verilog/asso_core.sv
// Bus-attached datapath for the rotate, subtract, xor, swap and sleep ops
//
// Behaviour
// (RQ1) Sleep clears power-down flag, sets time-out flag
// (RQ2) Sleep zeroes watchdog counter and its prescaler
// (RQ3) After sleep, halt; no further ops execute
// (RQ4) Rotate right through carry; only carry changes
// (RQ5) Destination bit 0 to work, 1 to file
// (RQ6) Literal minus work into work; C, DC, Z
// (RQ7) Carry set when work <= literal; nibble likewise
// (RQ8) File minus work; carry and digit by compare
// (RQ9) Xor literal into work; zero flag only
// (RQ10) Swap file nibbles; no flags change
// (RQ11) Xor work with file; zero flag only
// (RQ12) Zero flag set exactly when result is zero
// (RQ13) Bit 0 into carry, old carry into bit 7
`timescale 1ns/1ps
module asso_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [asso_pkg::BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [asso_pkg::BUS_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [asso_pkg::BUS_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Core state seen by the rest of the chip
    output logic oscillatorStopped,
    output logic powerDownFlag,
    output logic timeOutFlag
);
    import asso_pkg::*;

    // Bus handshake
    logic accepted; // Second cycle of a request
    logic takeEdge; // Edge at which the request completes
    logic [31:0] laneMask; // Byte enables widened to bits

    // Decoded register selects
    logic selCommand;
    logic selWork;
    logic selStatus;
    logic selFileIndex;
    logic selFileData;
    logic selWatchdog;

    // Architectural state
    asso_state_e state; // Running or asleep
    logic [7:0] work; // Working register
    logic carry; // Carry flag
    logic digitCarryFlag; // Digit carry flag
    logic zero; // Zero flag
    logic [7:0] fileMem [0:FILE_DEPTH-1]; // Data register file
    logic [6:0] fileIndex; // Bus pointer into the file
    logic [23:0] command; // Last command written
    logic [7:0] watchdogCounter; // Watchdog count
    logic [7:0] prescaler; // Watchdog prescaler
    logic watchdogTick; // Prescaler wrap enable

    // Command being issued this cycle
    logic [31:0] next_command; // Command image after byte merge
    logic fire; // Execute this cycle
    asso_op_e issueOp; // Operation field
    logic issueDest; // Destination field
    logic [6:0] issueAddr; // File address field
    logic [7:0] issueLit; // Literal field
    logic [7:0] issueFile; // Addressed file value

    // Datapath answers
    logic [7:0] aluResult;
    logic aluCarry;
    logic aluDigit;
    logic aluZero;
    logic aluWork;
    logic aluFile;
    logic aluTouchC;
    logic aluTouchDc;
    logic aluTouchZ;

    // Other merged write images
    logic [31:0] next_work;
    logic [31:0] next_status;
    logic [31:0] next_fileIndex;
    logic [31:0] next_fileData;
    logic [31:0] statusImage; // Status as read
    logic [31:0] readMux; // Selected read value

    // One wait cycle per request, then completion
    always_ff @(posedge clk) begin
        if (rst) begin
            accepted <= 1'b0;
        end else if ((avs_read | avs_write) & ~accepted) begin
            accepted <= 1'b1;
        end else begin
            accepted <= 1'b0;
        end
    end

    // Wait request drops on the completing cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~accepted;
    assign takeEdge = (avs_read | avs_write) & accepted;

    // Byte enables widened lane by lane
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign laneMask[lane*8 +: 8] = {8{avs_byteenable[lane]}};
        end
    endgenerate

    // Address decode
    always_comb begin
        selCommand = (avs_address == OFS_COMMAND);
        selWork = (avs_address == OFS_WORK);
        selStatus = (avs_address == OFS_STATUS);
        selFileIndex = (avs_address == OFS_FILE_INDEX);
        selFileData = (avs_address == OFS_FILE_DATA);
        selWatchdog = (avs_address == OFS_WATCHDOG);
    end

    // Status image with read-only flags
    always_comb begin
        statusImage = READ_ZERO;
        statusImage[ST_CARRY] = carry;
        statusImage[ST_DIGIT] = digitCarryFlag;
        statusImage[ST_ZERO] = zero;
        statusImage[ST_POWER_DOWN] = powerDownFlag;
        statusImage[ST_TIME_OUT] = timeOutFlag;
        statusImage[ST_ASLEEP] = (state == ASSO_ASLEEP);
    end

    // Merge write data into each register image
    always_comb begin
        next_command = ({8'h00, command} & ~laneMask)
            | (avs_writedata & laneMask);
        next_work = ({24'h000000, work} & ~laneMask)
            | (avs_writedata & laneMask);
        next_status = (statusImage & ~laneMask)
            | (avs_writedata & laneMask);
        next_fileIndex = ({25'h0, fileIndex} & ~laneMask)
            | (avs_writedata & laneMask);
        next_fileData = ({24'h000000, fileMem[fileIndex]} & ~laneMask)
            | (avs_writedata & laneMask);
    end

    // Command fields; sleeping core issues nothing
    always_comb begin
        issueOp = asso_op_e'(next_command[CMD_OP_LSB +: CMD_OP_W]);
        issueDest = next_command[CMD_DEST_BIT];
        issueAddr = next_command[CMD_ADDR_LSB +: FADDR_W]; // RQ4
        issueLit = next_command[CMD_LIT_LSB +: DATA_W];
        issueFile = fileMem[issueAddr];
        fire = takeEdge & avs_write & selCommand
            & (state == ASSO_RUN); // RQ3
    end

    // Instruction datapath
    asso_alu u_alu (
        .op(issueOp),
        .dest(issueDest),
        .literal(issueLit),
        .work(work),
        .fileValue(issueFile),
        .carryIn(carry),
        .result(aluResult),
        .carryOut(aluCarry),
        .digitOut(aluDigit),
        .zeroOut(aluZero),
        .writeWork(),
        .writeFile(aluFile),
        .touchCarry(aluTouchC),
        .touchDigit(aluTouchDc),
        .touchZero(aluTouchZ)
    );

    // Result goes to work unless steered to the file or the op is sleep or no-op
    assign aluWork = (issueOp != ASSO_SLEEP_OP)
        & (issueOp != ASSO_NO_OP) & ~aluFile; // RQ5

    // Last command kept for read-back
    always_ff @(posedge clk) begin
        if (rst) begin
            command <= CMD_RST;
        end else if (takeEdge & avs_write & selCommand) begin
            command <= next_command[CMD_W-1:0];
        end
    end

    // Run state; sleep halts, wake bit resumes
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ASSO_RUN;
        end else begin
            case (state)
                ASSO_RUN: begin
                    if (fire & (issueOp == ASSO_SLEEP_OP)) begin
                        state <= ASSO_ASLEEP; // RQ3
                    end
                end
                ASSO_ASLEEP: begin
                    if (takeEdge & avs_write & selStatus
                        & next_status[ST_WAKE]) begin
                        state <= ASSO_RUN;
                    end
                end
                default: begin
                    state <= ASSO_RUN;
                end
            endcase
        end
    end

    // Oscillator stop moves on the same edges as the run state
    always_ff @(posedge clk) begin
        if (rst) begin
            oscillatorStopped <= 1'b0;
        end else if (fire & (issueOp == ASSO_SLEEP_OP)) begin
            oscillatorStopped <= 1'b1; // RQ3
        end else if (takeEdge & avs_write & selStatus
            & next_status[ST_WAKE]) begin
            oscillatorStopped <= 1'b0;
        end
    end

    // Power-down and time-out flags
    always_ff @(posedge clk) begin
        if (rst) begin
            powerDownFlag <= 1'b1;
            timeOutFlag <= 1'b1;
        end else if (fire & (issueOp == ASSO_SLEEP_OP)) begin
            powerDownFlag <= 1'b0; // RQ1
            timeOutFlag <= 1'b1; // RQ1
        end
    end

    // Working register
    always_ff @(posedge clk) begin
        if (rst) begin
            work <= WORK_RST;
        end else if (fire & aluWork) begin
            work <= aluResult; // RQ5
        end else if (takeEdge & avs_write & selWork) begin
            work <= next_work[DATA_W-1:0];
        end
    end

    // Carry flag
    always_ff @(posedge clk) begin
        if (rst) begin
            carry <= 1'b0;
        end else if (fire & aluTouchC) begin
            carry <= aluCarry; // RQ4 RQ7 RQ8
        end else if (takeEdge & avs_write & selStatus) begin
            carry <= next_status[ST_CARRY];
        end
    end

    // Digit carry flag
    always_ff @(posedge clk) begin
        if (rst) begin
            digitCarryFlag <= 1'b0;
        end else if (fire & aluTouchDc) begin
            digitCarryFlag <= aluDigit; // RQ7 RQ8
        end else if (takeEdge & avs_write & selStatus) begin
            digitCarryFlag <= next_status[ST_DIGIT];
        end
    end

    // Zero flag
    always_ff @(posedge clk) begin
        if (rst) begin
            zero <= 1'b0;
        end else if (fire & aluTouchZ) begin
            zero <= aluZero; // RQ12
        end else if (takeEdge & avs_write & selStatus) begin
            zero <= next_status[ST_ZERO];
        end
    end

    // File pointer for bus access
    always_ff @(posedge clk) begin
        if (rst) begin
            fileIndex <= FIDX_RST;
        end else if (takeEdge & avs_write & selFileIndex) begin
            fileIndex <= next_fileIndex[FADDR_W-1:0];
        end
    end

    // Data register file, written back or by the bus
    always_ff @(posedge clk) begin
        if (fire & aluFile) begin
            fileMem[issueAddr] <= aluResult; // RQ5
        end else if (takeEdge & avs_write & selFileData) begin
            fileMem[fileIndex] <= next_fileData[DATA_W-1:0];
        end
    end

    // Prescaler wrap makes the watchdog enable
    assign watchdogTick = (prescaler == PRESC_LAST);

    // Watchdog prescaler
    always_ff @(posedge clk) begin
        if (rst) begin
            prescaler <= PRESC_RST;
        end else if (fire & (issueOp == ASSO_SLEEP_OP)) begin
            prescaler <= PRESC_RST; // RQ2
        end else begin
            prescaler <= prescaler + 8'h01;
        end
    end

    // Watchdog counter
    always_ff @(posedge clk) begin
        if (rst) begin
            watchdogCounter <= WDOG_RST;
        end else if (fire & (issueOp == ASSO_SLEEP_OP)) begin
            watchdogCounter <= WDOG_RST; // RQ2
        end else if (watchdogTick) begin
            watchdogCounter <= watchdogCounter + 8'h01;
        end
    end

    // Read multiplexer; unmapped reads give zero
    always_comb begin
        readMux = READ_ZERO;
        if (selCommand) begin
            readMux = {8'h00, command};
        end else if (selWork) begin
            readMux = {24'h000000, work};
        end else if (selStatus) begin
            readMux = statusImage;
        end else if (selFileIndex) begin
            readMux = {25'h0, fileIndex};
        end else if (selFileData) begin
            readMux = {24'h000000, fileMem[fileIndex]};
        end else if (selWatchdog) begin
            readMux = {24'h000000, watchdogCounter};
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= READ_ZERO;
        end else if (avs_read & ~accepted) begin
            avs_readdata <= readMux;
        end
    end
endmodule

// ===== test/asso_core_assertions.sv
// Port-level checker for the ALU subset datapath
`timescale 1ns/1ps
module asso_core_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus slave side
    input wire logic [asso_pkg::BUS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [asso_pkg::BUS_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [asso_pkg::BUS_DW-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Core state
    input wire logic oscillatorStopped,
    input wire logic powerDownFlag,
    input wire logic timeOutFlag
);
    import asso_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Completed write with the low lane enabled
    wire logic wrTake = avs_write && !avs_waitrequest && avs_byteenable[0];
    // Sleep command taken while running
    wire logic sleepTake = wrTake && avs_address == OFS_COMMAND &&
        avs_writedata[2:0] == ASSO_SLEEP_OP && !oscillatorStopped;
    // Wake request taken
    wire logic wakeTake = wrTake && avs_address == OFS_STATUS &&
        avs_writedata[ST_WAKE];
    // Completed status read
    wire logic statusRead = avs_read && !avs_waitrequest &&
        avs_address == OFS_STATUS;

    property p_sleep_flags;
        sleepTake |=> !powerDownFlag && timeOutFlag;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("status flags wrong after sleep");

    property p_sleep_halt;
        sleepTake |=> oscillatorStopped;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt)
        else $error("oscillator still running after sleep");

    property p_stay_asleep;
        oscillatorStopped && !wakeTake |=> oscillatorStopped;
    endproperty
    a_stay_asleep: assert property (p_stay_asleep)
        else $error("core left sleep without wake");

    property p_stay_awake;
        !oscillatorStopped && !sleepTake |=> !oscillatorStopped;
    endproperty
    a_stay_awake: assert property (p_stay_awake)
        else $error("oscillator stopped without sleep");

    property p_pd_stable;
        !sleepTake |=> $stable(powerDownFlag);
    endproperty
    a_pd_stable: assert property (p_pd_stable)
        else $error("power-down flag moved without sleep");

    property p_to_stable;
        !sleepTake |=> $stable(timeOutFlag);
    endproperty
    a_to_stable: assert property (p_to_stable)
        else $error("time-out flag moved without sleep");

    property p_status_read;
        statusRead |-> avs_readdata[5:3] ==
            {oscillatorStopped, timeOutFlag, powerDownFlag};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status readback disagrees with flag pins");

    property p_wait_first;
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait_first: assert property (p_wait_first)
        else $error("request not answered after one wait cycle");
endmodule

bind asso_core asso_core_assertions u_asso_chk (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .oscillatorStopped(oscillatorStopped),
    .powerDownFlag(powerDownFlag), .timeOutFlag(timeOutFlag)
);

// ===== test/test_alu_subset_sleep_ops.sv
// Self-checking bench for the ALU subset datapath
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_alu_subset_sleep_ops;
    import asso_pkg::*;
    // Design inputs, all defined at time zero
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hf;
    // Design outputs
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic oscillatorStopped;
    logic powerDownFlag;
    logic timeOutFlag;
    // Bench state
    int mismatches = 0;
    int checks = 0;
    logic [31:0] q;
    logic [10:0] expd;
    logic [6:0] fa;
    logic toWork;
    // Vectors: op, dest, literal, file, work, status
    logic [39:0] vec [15] = '{
        40'h01_00_02_00_07, 40'h00_00_81_00_00, 40'h10_05_00_05_00,
        40'h10_10_00_01_07, 40'h11_01_00_02_07, 40'h10_ff_00_00_00,
        40'h20_00_20_21_00, 40'h21_00_37_37_00, 40'h21_00_80_0f_07,
        40'h30_5a_00_5a_03, 40'h30_ff_00_0f_04, 40'h40_00_3c_3c_03,
        40'h41_00_f0_0f_04, 40'h50_00_a5_00_05, 40'h51_00_10_00_02};

    // Clock of 100 ns period
    always #50 clk = ~clk;

    asso_core dut (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .oscillatorStopped(oscillatorStopped),
        .powerDownFlag(powerDownFlag), .timeOutFlag(timeOutFlag));

    // Prints counts and verdict, then stops
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One bus transfer, held until waitrequest is seen low
    task automatic acc(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // Sample waitrequest at each rising edge until it is low
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                mismatches++;
                close_out();
            end
        end while (avs_waitrequest !== 1'b0);
        // Completing edge: take read data, then release
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    // Register write
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    // Register read compared under a mask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                       input logic [31:0] m);
        acc(1'b0, a, 32'h00000000);
        `CHK(q & m, e)
    endtask

    // Expected {zero, digit, carry, result} of one operation
    function automatic logic [10:0] model(input logic [2:0] op,
        input logic [7:0] lit, input logic [7:0] f, input logic [7:0] w,
        input logic [2:0] st);
        logic [7:0] r;
        logic [7:0] src;
        logic [2:0] s;
        s = st;
        src = (op == 3'h1 || op == 3'h3) ? lit : f;
        case (op)
            3'h0: begin
                r = {st[0], f[7:1]};
                s[0] = f[0];
            end
            3'h1, 3'h2: begin
                r = src - w;
                s[0] = w <= src;
                s[1] = w[3:0] <= src[3:0];
                s[2] = r == 8'h00;
            end
            3'h3, 3'h4: begin
                r = w ^ src;
                s[2] = r == 8'h00;
            end
            default: r = {f[3:0], f[7:4]};
        endcase
        return {s, r};
    endfunction

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc(OFS_STATUS, 32'h18, 32'h3f);
        rdc(OFS_WORK, 32'h0, 32'hffffffff);
        wr(OFS_STATUS, 32'h3f);
        rdc(OFS_STATUS, 32'h1f, 32'h3f);
        wr(5'h1c, 32'hffffffff);
        rdc(5'h1c, 32'h0, 32'hffffffff);
        for (int i = 0; i < 15; i++) begin
            fa = 7'(127 - 8 * i);
            toWork = !vec[i][32] || vec[i][38:36] inside {3'h1, 3'h3};
            wr(OFS_FILE_INDEX, {25'h0, fa});
            wr(OFS_FILE_DATA, {24'h0, vec[i][23:16]});
            wr(OFS_WORK, {24'h0, vec[i][15:8]});
            wr(OFS_STATUS, {29'h0, vec[i][2:0]});
            wr(OFS_COMMAND, {8'h00, vec[i][31:24], 5'h00, fa,
                vec[i][32], vec[i][38:36]});
            expd = model(vec[i][38:36], vec[i][31:24], vec[i][23:16],
                vec[i][15:8], vec[i][2:0]);
            rdc(OFS_WORK, {24'h0, toWork ? expd[7:0] : vec[i][15:8]},
                32'hff);
            rdc(OFS_FILE_DATA, {24'h0, toWork ? vec[i][23:16] : expd[7:0]},
                32'hff);
            rdc(OFS_STATUS, {26'h0, 3'b011, expd[10:8]}, 32'h3f);
        end
        // Let the watchdog advance, then put the core to sleep
        repeat (300) @(posedge clk);
        acc(1'b0, OFS_WATCHDOG, 32'h0);
        `CHK(q[7:0] != 8'h00, 1'b1)
        wr(OFS_WORK, 32'h33);
        wr(OFS_COMMAND, {29'h0, ASSO_SLEEP_OP});
        `CHK({oscillatorStopped, powerDownFlag, timeOutFlag}, 3'b101)
        rdc(OFS_WATCHDOG, 32'h0, 32'hffffffff);
        rdc(OFS_STATUS, 32'h30, 32'h38);
        wr(OFS_COMMAND, {8'h00, 8'hff, 13'h0, ASSO_XOR_LITERAL_OP});
        rdc(OFS_WORK, 32'h33, 32'hffffffff);
        // Wake and confirm execution resumes
        wr(OFS_STATUS, 32'h80);
        `CHK(oscillatorStopped, 1'b0)
        wr(OFS_COMMAND, {8'h00, 8'hff, 13'h0, ASSO_XOR_LITERAL_OP});
        rdc(OFS_WORK, 32'hcc, 32'hffffffff);
        // No-operation leaves work alone
        wr(OFS_COMMAND, {29'h0, ASSO_NO_OP});
        rdc(OFS_WORK, 32'hcc, 32'hffffffff);
        close_out();
    end
endmodule
